// File: lockout_pkg.sv
// Package with constants and carrier types for the flash security and lockout recovery block.
package lockout_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned ERASE_TIME_US   = 100;
    localparam int unsigned ERASE_CYCLES    = (ERASE_TIME_US * (CLK_HZ / 1_000_000));

    // ------------------------------------------------------------------
    // JTAG instruction register and data register
    // ------------------------------------------------------------------
    localparam int unsigned IR_W            = 4;
    localparam logic [3:0]  IR_IDCODE       = 4'h2;
    localparam logic [3:0]  IR_LOCKOUT      = 4'h5;
    localparam logic [3:0]  IR_BYPASS       = 4'hF;
    localparam int unsigned DIVR_W          = 7;
    localparam int unsigned PRESCALE_BIT    = 6;
    localparam logic [31:0] IDCODE_VALUE    = 32'h1234_5001; // Arbitrary identification value.

    // ------------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_FDIV       = 4'h8;
    localparam logic [3:0]  ADDR_KEY        = 4'hC;
    localparam int unsigned CTRL_SEC_BIT    = 0;
    localparam int unsigned CTRL_BACKDOOR_KEY_ENABLE_BIT  = 1;
    localparam int unsigned CTRL_UNLK_BIT   = 2;
    localparam logic [15:0] KEY_RESET       = 16'h0000;

    // ------------------------------------------------------------------
    // TAP states (IEEE 1149.1 encoding)
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR  = 4'hF, RTI  = 4'hC, SDRS = 4'h7, CDR  = 4'h6,
        SDR  = 4'h2, E1DR = 4'h1, PDR  = 4'h3, E2DR = 4'h0,
        UDR  = 4'h5, SIRS = 4'h4, CIR  = 4'hE, SIR  = 4'hA,
        E1IR = 4'h9, PIR  = 4'hB, E2IR = 4'h8, UIR  = 4'hD
    } tap_state_t;

    // Flash clock divider carrier: prescale bit plus six-bit ratio.
    typedef struct packed {
        logic       prescale_by_eight;
        logic [5:0] div;
    } flash_div_t;

    // Flash erase engine states.
    typedef enum logic [1:0] {
        ER_IDLE = 2'b00,
        ER_RUN  = 2'b01,
        ER_DONE = 2'b10
    } erase_state_t;

endpackage

// File: flash_erase_timer.sv
// Flash clock divider and mass-erase sequencer of the flash module.
`timescale 1ns/10ps

module flash_erase_timer
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Divider and command
    input  wire lockout_pkg::flash_div_t fdiv,
    input  wire logic                    start,
    // Status
    output logic                         busy,
    output logic                         done_pulse
);

    lockout_pkg::erase_state_t st_q, st_d;
    logic [2:0]  half_q, half_d;
    logic [2:0]  pre_q, pre_d;
    logic [5:0]  div_q, div_d;
    logic [15:0] tick_q, tick_d;
    logic        fclk_tick;

    // ------------------------------------------------------------------
    // Divider chain and erase timing
    // ------------------------------------------------------------------
    // Input clock is the system clock over two, then optionally over eight, then over ratio plus one.
    always_comb
    begin
        half_d    = half_q + 3'h1;
        pre_d     = pre_q;
        div_d     = div_q;
        fclk_tick = 1'b0;
        if (half_q[0])
        begin
            pre_d = pre_q + 3'h1;
            if (!fdiv.prescale_by_eight || (pre_q == 3'h7))
            begin
                if (div_q == fdiv.div)
                begin
                    div_d     = 6'h00;
                    fclk_tick = 1'b1;
                end
                else
                    div_d = div_q + 6'h01;
            end
        end
        st_d       = st_q;
        tick_d     = tick_q;
        done_pulse = 1'b0;
        unique case (st_q)
            lockout_pkg::ER_IDLE:
                if (start)
                begin
                    st_d   = lockout_pkg::ER_RUN;
                    tick_d = 16'h0000;
                end
            lockout_pkg::ER_RUN:
                if (fclk_tick)
                begin
                    if (tick_q == 16'(lockout_pkg::ERASE_CYCLES / 250))
                        st_d = lockout_pkg::ER_DONE;
                    else
                        tick_d = tick_q + 16'h0001;
                end
            lockout_pkg::ER_DONE:
            begin
                done_pulse = 1'b1;
                st_d       = lockout_pkg::ER_IDLE;
            end
            default:
                st_d = lockout_pkg::ER_IDLE;
        endcase
        busy = (st_q == lockout_pkg::ER_RUN);
    end

    // Registers of the divider chain and sequencer.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q   <= lockout_pkg::ER_IDLE;
            half_q <= 3'h0;
            pre_q  <= 3'h0;
            div_q  <= 6'h00;
            tick_q <= 16'h0000;
        end
        else
        begin
            st_q   <= st_d;
            half_q <= half_d;
            pre_q  <= pre_d;
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

endmodule // flash_erase_timer

// File: flash_security_lockout.sv
// Flash security interlock, chip TAP with lockout recovery, and Wishbone control registers.
`timescale 1ns/10ps

// Operation
// - Chip TAP active after boot, ID and lockout.
// - Security drives core debug read block.
// - Security bytes set read block at reset.
// - Recovery erases all flash, clearing security.
// - Lockout instruction selects seven-bit divider register.
// - JTAG divider replaces flash divider during recovery.
// - Bit six prescale, bits five-zero ratio.
// - Clock over two, optional eight, ratio+1.
// - Erase starts on entering Run-Test/Idle under the lockout instruction.
// - Backdoor unlock only when key enable set.
// - Security only disables the debug port.
// - Reset released only on system clock edge.
module flash_security_lockout
(
    // System clock and chip reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // JTAG pins, asynchronous to clk
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    input  wire logic        trst_n,
    output logic             tdo,
    output logic             tdo_oe,
    // Non-volatile security state sampled at reset
    input  wire logic        nv_secure,
    input  wire logic        nv_key_enable,
    input  wire logic [15:0] nv_backdoor_key,
    // Core debug port interlock
    output logic             core_debug_port_block,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       srst_n;
    logic [1:0] tck_s_q, tms_s_q, tdi_s_q, trst_s_q;
    logic       tck_prev_q;

    // Reset asserts at once but leaves only on a rising system clock edge.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign srst_n = rst_sync_q[1];

    // The JTAG pins are oversampled; tck must stay under an eighth of clk, as tdo follows a tck fall by three clk cycles.
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            tck_s_q    <= 2'b00;
            tms_s_q    <= 2'b11;
            tdi_s_q    <= 2'b00;
            trst_s_q   <= 2'b00;
            tck_prev_q <= 1'b0;
        end
        else
        begin
            tck_s_q    <= {tck_s_q[0], tck};
            tms_s_q    <= {tms_s_q[0], tms};
            tdi_s_q    <= {tdi_s_q[0], tdi};
            trst_s_q   <= {trst_s_q[0], trst_n};
            tck_prev_q <= tck_s_q[1];
        end
    end

    logic tck_rise, tck_fall, tap_rst;
    assign tck_rise = tck_s_q[1] & ~tck_prev_q;
    assign tck_fall = ~tck_s_q[1] & tck_prev_q;
    assign tap_rst  = ~trst_s_q[1];

    // ------------------------------------------------------------------
    // TAP controller and shift registers
    // ------------------------------------------------------------------
    lockout_pkg::tap_state_t    tap_q, tap_d;
    logic [lockout_pkg::IR_W-1:0]   ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [31:0]                dr_sh_q, dr_sh_d;
    lockout_pkg::flash_div_t    jdiv_q, jdiv_d;
    logic                       tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
    logic                       lockout_sel;
    logic                       rti_enter;

    assign lockout_sel = (ir_q == lockout_pkg::IR_LOCKOUT);

    // State walk, shift and update follow the standard TAP on sampled edges.
    always_comb
    begin
        tap_d     = tap_q;
        ir_sh_d   = ir_sh_q;
        ir_d      = ir_q;
        dr_sh_d   = dr_sh_q;
        jdiv_d    = jdiv_q;
        tdo_d     = tdo_q;
        tdo_oe_d  = tdo_oe_q;
        rti_enter = 1'b0;
        if (tck_rise)
        begin
            unique case (tap_q)
                lockout_pkg::TLR:  tap_d = tms_s_q[1] ? lockout_pkg::TLR  : lockout_pkg::RTI;
                lockout_pkg::RTI:  tap_d = tms_s_q[1] ? lockout_pkg::SDRS : lockout_pkg::RTI;
                lockout_pkg::SDRS: tap_d = tms_s_q[1] ? lockout_pkg::SIRS : lockout_pkg::CDR;
                lockout_pkg::CDR:  tap_d = tms_s_q[1] ? lockout_pkg::E1DR : lockout_pkg::SDR;
                lockout_pkg::SDR:  tap_d = tms_s_q[1] ? lockout_pkg::E1DR : lockout_pkg::SDR;
                lockout_pkg::E1DR: tap_d = tms_s_q[1] ? lockout_pkg::UDR  : lockout_pkg::PDR;
                lockout_pkg::PDR:  tap_d = tms_s_q[1] ? lockout_pkg::E2DR : lockout_pkg::PDR;
                lockout_pkg::E2DR: tap_d = tms_s_q[1] ? lockout_pkg::UDR  : lockout_pkg::SDR;
                lockout_pkg::UDR:  tap_d = tms_s_q[1] ? lockout_pkg::SDRS : lockout_pkg::RTI;
                lockout_pkg::SIRS: tap_d = tms_s_q[1] ? lockout_pkg::TLR  : lockout_pkg::CIR;
                lockout_pkg::CIR:  tap_d = tms_s_q[1] ? lockout_pkg::E1IR : lockout_pkg::SIR;
                lockout_pkg::SIR:  tap_d = tms_s_q[1] ? lockout_pkg::E1IR : lockout_pkg::SIR;
                lockout_pkg::E1IR: tap_d = tms_s_q[1] ? lockout_pkg::UIR  : lockout_pkg::PIR;
                lockout_pkg::PIR:  tap_d = tms_s_q[1] ? lockout_pkg::E2IR : lockout_pkg::PIR;
                lockout_pkg::E2IR: tap_d = tms_s_q[1] ? lockout_pkg::UIR  : lockout_pkg::SIR;
                lockout_pkg::UIR:  tap_d = tms_s_q[1] ? lockout_pkg::SDRS : lockout_pkg::RTI;
            endcase
            rti_enter = (tap_d == lockout_pkg::RTI) && (tap_q != lockout_pkg::RTI);
            unique case (tap_q)
                lockout_pkg::TLR:
                    ir_d = lockout_pkg::IR_IDCODE;
                lockout_pkg::CIR:
                    ir_sh_d = 4'h1;
                lockout_pkg::SIR:
                    ir_sh_d = {tdi_s_q[1], ir_sh_q[lockout_pkg::IR_W-1:1]};
                lockout_pkg::UIR:
                    ir_d = ir_sh_q;
                lockout_pkg::CDR:
                    if (ir_q == lockout_pkg::IR_IDCODE)
                        dr_sh_d = lockout_pkg::IDCODE_VALUE;
                    else if (lockout_sel)
                        dr_sh_d = {25'h0, jdiv_q};
                    else
                        dr_sh_d = 32'h0000_0000;
                lockout_pkg::SDR:
                    if (ir_q == lockout_pkg::IR_IDCODE)
                        dr_sh_d = {tdi_s_q[1], dr_sh_q[31:1]};
                    else if (lockout_sel)
                        dr_sh_d = {25'h0, tdi_s_q[1], dr_sh_q[6:1]};
                    else
                        dr_sh_d = {31'h0, tdi_s_q[1]};
                lockout_pkg::UDR:
                    if (lockout_sel)
                        jdiv_d = dr_sh_q[6:0];
                default:
                    ;
            endcase
        end
        if (tck_fall)
        begin
            tdo_oe_d = (tap_q == lockout_pkg::SDR) || (tap_q == lockout_pkg::SIR);
            tdo_d    = (tap_q == lockout_pkg::SIR) ? ir_sh_q[0] : dr_sh_q[0];
        end
    end

    // TAP registers; trst resets the state, instruction and tdo_oe through its synchronised level.
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            tap_q    <= lockout_pkg::TLR;
            ir_sh_q  <= 4'h0;
            ir_q     <= lockout_pkg::IR_IDCODE;
            dr_sh_q  <= 32'h0000_0000;
            jdiv_q   <= 7'h00;
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else if (tap_rst)
        begin
            tap_q    <= lockout_pkg::TLR;
            ir_q     <= lockout_pkg::IR_IDCODE;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tap_q    <= tap_d;
            ir_sh_q  <= ir_sh_d;
            ir_q     <= ir_d;
            dr_sh_q  <= dr_sh_d;
            jdiv_q   <= jdiv_d;
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end
    assign tdo    = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ------------------------------------------------------------------
    // Security state, divider selection and erase engine
    // ------------------------------------------------------------------
    logic                    secure_q, secure_d, backdoor_key_enable_q, backdoor_key_enable_d, strap_q, strap_d;
    logic                    recov_q, recov_d, erased_q, erased_d;
    logic [15:0]             key_q, key_d;
    lockout_pkg::flash_div_t fdiv_reg_q, fdiv_reg_d, fdiv_sel;
    logic                    er_busy, er_done, er_start;
    logic                    wb_hit;
    logic                    ack_q, ack_d;
    logic [31:0]             rd_q, rd_d;

    // Only the lockout instruction may override the divider and start an erase.
    assign fdiv_sel = (recov_q && lockout_sel) ? jdiv_q : fdiv_reg_q;
    assign er_start = rti_enter && lockout_sel && !recov_q;

    flash_erase_timer u_erase
    (
        .clk        (clk),
        .rst_n      (srst_n),
        .fdiv       (fdiv_sel),
        .start      (er_start),
        .busy       (er_busy),
        .done_pulse (er_done)
    );

    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;

    // Security loads once after reset release; software only touches the divider and, through the key unlock, security.
    always_comb
    begin
        strap_d    = 1'b1;
        secure_d   = secure_q;
        backdoor_key_enable_d    = backdoor_key_enable_q;
        key_d      = key_q;
        recov_d    = recov_q;
        erased_d   = erased_q;
        fdiv_reg_d = fdiv_reg_q;
        ack_d      = wb_hit;
        rd_d       = 32'h0000_0000;
        if (!strap_q)
        begin
            secure_d = nv_secure & ~erased_q;
            backdoor_key_enable_d  = nv_key_enable;
            key_d    = nv_backdoor_key;
        end
        if (er_start)
            recov_d = 1'b1;
        if (er_done)
        begin
            recov_d  = 1'b0;
            erased_d = 1'b1;
            secure_d = 1'b0;
            key_d    = lockout_pkg::KEY_RESET;
        end
        if (wb_hit && wb_we_i && wb_sel_i[0])
        begin
            unique case (wb_adr_i)
                lockout_pkg::ADDR_FDIV:
                    fdiv_reg_d = wb_dat_i[6:0];
                lockout_pkg::ADDR_CTRL:
                    if (wb_dat_i[lockout_pkg::CTRL_UNLK_BIT] && backdoor_key_enable_q && (wb_dat_i[31:16] == key_q))
                        secure_d = 1'b0;
                default:
                    ;
            endcase
        end
        if (wb_hit && !wb_we_i)
        begin
            unique case (wb_adr_i)
                lockout_pkg::ADDR_CTRL:   rd_d = {29'h0, 1'b0, backdoor_key_enable_q, secure_q};
                lockout_pkg::ADDR_STATUS: rd_d = {28'h0, erased_q, er_busy, recov_q, lockout_sel};
                lockout_pkg::ADDR_FDIV:   rd_d = {25'h0, fdiv_reg_q};
                default:                  rd_d = 32'h0000_0000;
            endcase
        end
    end

    // Security resets to the locked state until the strap is caught.
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            strap_q    <= 1'b0;
            secure_q   <= 1'b1;
            backdoor_key_enable_q    <= 1'b0;
            key_q      <= lockout_pkg::KEY_RESET;
            recov_q    <= 1'b0;
            erased_q   <= 1'b0;
            fdiv_reg_q <= 7'h00;
            ack_q      <= 1'b0;
            rd_q       <= 32'h0000_0000;
        end
        else
        begin
            strap_q    <= strap_d;
            secure_q   <= secure_d;
            backdoor_key_enable_q    <= backdoor_key_enable_d;
            key_q      <= key_d;
            recov_q    <= recov_d;
            erased_q   <= erased_d;
            fdiv_reg_q <= fdiv_reg_d;
            ack_q      <= ack_d;
            rd_q       <= rd_d;
        end
    end

    // Only the debug read path is gated; execution never sees security.
    assign core_debug_port_block = secure_q;
    assign wb_ack_o              = ack_q;
    assign wb_dat_o              = rd_q;

endmodule // flash_security_lockout

// File: lockout_chk.sv
// Port assertions of the lockout block.
`timescale 1ns/10ps

module lockout_chk
(
    // Clock and resets
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        trst_n,
    // Strap and interlock
    input wire logic        nv_secure,
    input wire logic        nv_key_enable,
    input wire logic        tdo_oe,
    input wire logic        core_debug_port_block,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    // ------------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Open request, reset end, refused unlock.
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_release;
        $rose(rst_n);
    endsequence
    sequence s_locked_write;
        s_req ##0 (wb_we_i && wb_adr_i == lockout_pkg::ADDR_CTRL && !nv_key_enable && core_debug_port_block);
    endsequence

    property p_block_held;    s_release |-> core_debug_port_block [*3]; endproperty
    property p_block_strap;   s_release |-> ##6 (core_debug_port_block == nv_secure); endproperty
    property p_block_no_rise; !$rose(core_debug_port_block); endproperty
    property p_unlock_refused; s_locked_write |=> core_debug_port_block [*3]; endproperty
    property p_tap_quiet;     (!trst_n) [*5] |-> !tdo_oe; endproperty
    property p_ack_next;      s_req |=> wb_ack_o; endproperty
    property p_ack_pulse;     wb_ack_o |=> !wb_ack_o; endproperty
    property p_reserved_zero; s_req ##0 (!wb_we_i && wb_adr_i == lockout_pkg::ADDR_KEY) |=> wb_dat_o == 32'h0; endproperty

    // Labelled checks.
    a_block_held:     assert property (p_block_held) else $error("block fell early");
    a_block_strap:    assert property (p_block_strap) else $error("block not strap");
    a_block_no_rise:  assert property (p_block_no_rise) else $error("block rose");
    a_unlock_refused: assert property (p_unlock_refused) else $error("unlock without key enable");
    a_tap_quiet:      assert property (p_tap_quiet) else $error("tdo_oe in TAP reset");
    a_ack_next:       assert property (p_ack_next) else $error("ack late");
    a_ack_pulse:      assert property (p_ack_pulse) else $error("ack too long");
    a_reserved_zero:  assert property (p_reserved_zero) else $error("reserved read nonzero");
endmodule // lockout_chk

bind flash_security_lockout lockout_chk u_chk
(
    .clk(clk), .rst_n(rst_n), .trst_n(trst_n), .nv_secure(nv_secure), .nv_key_enable(nv_key_enable),
    .tdo_oe(tdo_oe), .core_debug_port_block(core_debug_port_block), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// File: jtag_host.sv
// Behavioural JTAG debug host.
`timescale 1ns/10ps

module jtag_host
(
    // Pacing clock
    input wire logic clk,
    // JTAG pins
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    output logic     trst_n,
    input wire logic tdo
);
    // ------------------------------------------------------------------
    // Pin sequencing
    // ------------------------------------------------------------------
    // tck idles low; it runs at clk/17, under the clk/8 limit.
    initial
    begin
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b0;
        trst_n = 1'b0;
    end

    // One tck period; tdo taken just before the rise.
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk);
        o = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge clk);
        tck <= 1'b0;
    endtask

    // Pulse TAP reset, then park in RTI.
    task automatic tap_reset();
        logic o;
        @(posedge clk);
        trst_n <= 1'b0;
        repeat (10) @(posedge clk);
        trst_n <= 1'b1;
        repeat (10) @(posedge clk);
        step(1'b0, !tdi, o);
    endtask

    // Shift n bits through IR or DR, back to RTI; idle tdi toggles.
    task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        step(1'b1, !tdi, o);
        if (ir)
            step(1'b1, !tdi, o);
        step(1'b0, !tdi, o);
        step(1'b0, !tdi, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, !tdi, o);
        step(1'b0, !tdi, o);
    endtask
endmodule // jtag_host

// File: flash_security_lockout_tb.sv
// Testbench of the lockout block.
`timescale 1ns/10ps

module flash_security_lockout_tb;
    typedef struct packed { logic we; logic [3:0] adr; logic [31:0] wd; logic [31:0] exp; } row_t;

    // Ratio 15 with prescale: 50 MHz / 2 / 8 / 16 is about 195 kHz.
    localparam logic [15:0] KEY   = 16'hA5C3;
    localparam logic [6:0]  DIV_W = 7'h4F;
    localparam int          ERASE = (lockout_pkg::ERASE_CYCLES / 250 + 1) * 2 * 8 * 16;
    localparam row_t        ROWS [10] = '{
        '{1'b0, lockout_pkg::ADDR_CTRL, 32'h0, 32'h1}, '{1'b0, lockout_pkg::ADDR_STATUS, 32'h0, 32'h0},
        '{1'b1, lockout_pkg::ADDR_FDIV, 32'h49, 32'h0}, '{1'b0, lockout_pkg::ADDR_FDIV, 32'h0, 32'h49},
        '{1'b1, lockout_pkg::ADDR_FDIV, 32'hFFFF_FF13, 32'h0}, '{1'b0, lockout_pkg::ADDR_FDIV, 32'h0, 32'h13},
        '{1'b1, lockout_pkg::ADDR_KEY, 32'hFFFF_FFFF, 32'h0}, '{1'b0, lockout_pkg::ADDR_KEY, 32'h0, 32'h0},
        '{1'b1, lockout_pkg::ADDR_CTRL, {KEY, 16'h0004}, 32'h0}, '{1'b0, lockout_pkg::ADDR_CTRL, 32'h0, 32'h1}};

    logic        clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, blk;
    logic        nv_secure, nv_key_enable, wb_cyc, wb_stb, wb_we, wb_ack, busy;
    logic [3:0]  wb_adr;
    logic [31:0] wb_dat_i, wb_dat_o, rd, dr;
    int          num_errors, checked, cyc_cnt, c0, n;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycle count.
    always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

    flash_security_lockout dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo), .tdo_oe(tdo_oe), .nv_secure(nv_secure), .nv_key_enable(nv_key_enable),
        .nv_backdoor_key(KEY), .core_debug_port_block(blk), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack));
    jtag_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic timed_out();
        num_errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    // Classic cycle held until ack.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_i <= wd;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wb_ack !== 1'b1 && k < 50);
        q = wb_dat_o;
        if (wb_ack !== 1'b1)
            timed_out();
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // Chip reset with the given straps.
    task automatic do_reset(input logic sec, input logic ken);
        @(posedge clk);
        rst_n <= 1'b0;
        nv_secure <= sec;
        nv_key_enable <= ken;
        repeat (16) @(posedge clk);
        check({31'h0, blk}, 32'h1);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check({31'h0, blk}, {31'h0, sec});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, nv_secure, nv_key_enable, wb_cyc, wb_stb, wb_we} = 6'h0;
        {wb_adr, wb_dat_i, num_errors, checked, cyc_cnt} = '0;
        do_reset(1'b1, 1'b0);
        foreach (ROWS[i])
        begin
            wb(ROWS[i].we, ROWS[i].adr, ROWS[i].wd, rd);
            if (!ROWS[i].we)
                check(rd, ROWS[i].exp);
        end
        // Wrong key refused, right key unlocks.
        do_reset(1'b1, 1'b1);
        wb(1'b1, lockout_pkg::ADDR_CTRL, {~KEY, 16'h0004}, rd);
        wb(1'b0, lockout_pkg::ADDR_CTRL, 32'h0, rd);
        check(rd, 32'h3);
        wb(1'b1, lockout_pkg::ADDR_CTRL, {KEY, 16'h0004}, rd);
        wb(1'b0, lockout_pkg::ADDR_CTRL, 32'h0, rd);
        check(rd, 32'h2);
        check({31'h0, blk}, 32'h0);
        // Lockout recovery; RTI under ID must not erase.
        do_reset(1'b1, 1'b0);
        host.tap_reset();
        host.shift(1'b0, 32, 32'h0, dr);
        check(dr, lockout_pkg::IDCODE_VALUE);
        wb(1'b0, lockout_pkg::ADDR_STATUS, 32'h0, rd);
        check(rd, 32'h0);
        host.shift(1'b1, 4, {28'h0, lockout_pkg::IR_LOCKOUT}, dr);
        wb(1'b0, lockout_pkg::ADDR_STATUS, 32'h0, rd);
        check(rd & 32'h1, 32'h1);
        host.shift(1'b0, 7, {25'h0, DIV_W}, dr);
        c0 = cyc_cnt;
        busy = 1'b0;
        n = 0;
        // tck stays still in RTI until done.
        do
        begin
            wb(1'b0, lockout_pkg::ADDR_STATUS, 32'h0, rd);
            busy |= rd[2];
            n++;
        end
        while (rd[3] !== 1'b1 && n < 4000);
        if (rd[3] !== 1'b1)
            timed_out();
        check({31'h0, busy}, 32'h1);
        check({31'h0, (cyc_cnt - c0 > ERASE - 300) && (cyc_cnt - c0 < ERASE + 300)}, 32'h1);
        check({31'h0, blk}, 32'h0);
        // Both resets return to unsecured operation.
        host.tap_reset();
        do_reset(1'b0, 1'b0);
        wb(1'b0, lockout_pkg::ADDR_STATUS, 32'h0, rd);
        check(rd, 32'h0);
        tally_and_finish();
    end
endmodule // flash_security_lockout_tb
